// ==== rtl/bbcs_pkg.sv ====
// Shared constants, states and carrier types of the buck-boost control sequencer
package bbcs_pkg;

  // Register map, printed offsets
  localparam logic [7:0] REG_REFERENCE_LOW   = 8'h00;
  localparam logic [7:0] REG_REFERENCE_HIGH  = 8'h01;
  localparam logic [7:0] REG_FEEDBACK_SELECT = 8'h04;
  localparam logic [7:0] REG_OUTPUT_CONTROL  = 8'h06;

  // Reset values
  localparam logic [7:0] RST_REFERENCE_LOW   = 8'h00;
  localparam logic [2:0] RST_REFERENCE_HIGH  = 3'h0;
  localparam logic [7:0] RST_FEEDBACK_SELECT = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CONTROL  = 8'h00;

  // Field positions
  localparam int REF_HIGH_BITS         = 3;
  localparam int FB_SOURCE_BIT         = 7;
  localparam int RATIO_LSB             = 0;
  localparam int CTRL_OUTPUT_ENABLE    = 7;
  localparam int CTRL_FORCED_DISCHARGE = 5;
  localparam int CTRL_OFF_DISCHARGE    = 4;

  // Serial target addresses selected by the address-select pin
  localparam logic [6:0] ADDR_MODE_LOW  = 7'h75;
  localparam logic [6:0] ADDR_MODE_HIGH = 7'h74;

  // Timing
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned SOFT_START_NS      = 3600000;
  localparam int unsigned SOFT_START_CYCLES  = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_FULL_SCALE     = 2048;
  localparam int unsigned SYNC_WINDOW_NS     = 10000;
  localparam logic [7:0]  SYNC_WINDOW_CYCLES = 8'(SYNC_WINDOW_NS / CLK_PERIOD_NS);

  // Serial target states
  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_ADDR     = 4'h1,
    S_ADDR_ACK = 4'h2,
    S_PTR      = 4'h3,
    S_PTR_ACK  = 4'h4,
    S_WR       = 4'h5,
    S_WR_ACK   = 4'h6,
    S_RD       = 4'h7,
    S_RD_ACK   = 4'h8
  } bbcs_state_t;

  // Converter control levels toward the analog side
  typedef struct packed {
    logic       switching;
    logic       discharge;
    logic       dither;
    logic       feedback_external;
    logic [1:0] internal_divider_ratio;
  } bbcs_drive_t;

endpackage

// ==== rtl/bbcs_sequencer.sv ====
// Enable sequencing, serial register target and converter control of the buck-boost block
`timescale 1ns/1ns
`default_nettype none
module bbcs_sequencer #(
  parameter int unsigned SOFT_START_CYC = bbcs_pkg::SOFT_START_CYCLES
) (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                enable_lockout_pin_awake,
  input  wire logic                enable_lockout_pin_run,
  input  wire logic                mode_pin,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output var  logic                sda_out_r,
  output var  logic                sda_oe_r,
  input  wire logic                spread_or_sync_pin,
  input  wire logic                spread_pin_in_band,
  input  wire logic                vout_above_discharge_level,
  output var  logic [6:0]          target_address_r,
  output var  logic [10:0]         reference_code,
  output var  logic                soft_start_done,
  output var  bbcs_pkg::bbcs_drive_t drive_r
);
  import bbcs_pkg::*;

  localparam int unsigned STEP_RAW = SOFT_START_CYC / REF_FULL_SCALE;
  localparam int unsigned STEP_CYC = (STEP_RAW == 0) ? 1 : STEP_RAW;

  // Synchroniser: first stage feeds only the second
  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic       awake_s, run_s, mode_s, scl_s, sda_s, dpin_s, band_s, vout_hi_s;
  logic       awake_q, scl_q, sda_q, dpin_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r  <= 8'hC0;
      sync_r  <= 8'hC0;
      awake_q <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      dpin_q  <= 1'b0;
    end
    else
    begin
      meta_r  <= {scl_in, sda_in, enable_lockout_pin_awake, enable_lockout_pin_run, mode_pin,
                  spread_or_sync_pin, spread_pin_in_band, vout_above_discharge_level};
      sync_r  <= meta_r;
      awake_q <= awake_s;
      scl_q   <= scl_s;
      sda_q   <= sda_s;
      dpin_q  <= dpin_s;
    end
  end

  assign {scl_s, sda_s, awake_s, run_s, mode_s, dpin_s, band_s, vout_hi_s} = sync_r;

  // Bus conditions on the synchronised lines
  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;

  // Register file
  logic [7:0] ref_lo_r, ref_lo_nxt, fb_r, fb_nxt, ctrl_r, ctrl_nxt;
  logic [2:0] ref_hi_r, ref_hi_nxt;

  // Serial target state
  bbcs_state_t st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, rd_addr, rd_byte;
  logic        rw_r, rw_nxt, oe_nxt, wr_stb;

  // Read mux; during the master's acknowledge the next byte is fetched ahead
  always_comb
  begin
    rd_addr = (st_r == S_RD_ACK) ? ptr_r + 8'h01 : ptr_r;
    unique case (rd_addr)
      REG_REFERENCE_LOW:   rd_byte = ref_lo_r;
      REG_REFERENCE_HIGH:  rd_byte = {{(8 - REF_HIGH_BITS){1'b0}}, ref_hi_r};
      REG_FEEDBACK_SELECT: rd_byte = fb_r;
      REG_OUTPUT_CONTROL:  rd_byte = ctrl_r;
      default:             rd_byte = 8'h00;
    endcase
  end

  // Serial target next state; bits taken on SCL rise, SDA changed on SCL fall
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    tx_nxt  = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt  = rw_r;
    oe_nxt  = sda_oe_r;
    wr_stb  = 1'b0;
    if (!run_s)
    begin
      st_nxt = S_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start_det)
    begin
      st_nxt  = S_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end
    else if (stop_det)
    begin
      st_nxt = S_IDLE;
      oe_nxt = 1'b0;
    end
    else if (scl_rise && st_r != S_IDLE)
    begin
      sh_nxt = {sh_r[6:0], sda_s};
      if (cnt_r != 4'h8)
      begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (st_r)
        S_IDLE:
        begin
        end
        S_ADDR:
        begin
          if (cnt_r == 4'h8)
          begin
            if (sh_r[7:1] == target_address_r)
            begin
              rw_nxt = sh_r[0];
              oe_nxt = 1'b1;
              st_nxt = S_ADDR_ACK;
            end
            else
            begin
              st_nxt = S_IDLE;
            end
          end
        end
        S_ADDR_ACK:
        begin
          cnt_nxt = 4'h0;
          if (rw_r)
          begin
            tx_nxt = rd_byte;
            oe_nxt = !rd_byte[7];
            st_nxt = S_RD;
          end
          else
          begin
            oe_nxt = 1'b0;
            st_nxt = S_PTR;
          end
        end
        S_PTR:
        begin
          if (cnt_r == 4'h8)
          begin
            ptr_nxt = sh_r;
            oe_nxt  = 1'b1;
            st_nxt  = S_PTR_ACK;
          end
        end
        S_PTR_ACK, S_WR_ACK:
        begin
          oe_nxt  = 1'b0;
          cnt_nxt = 4'h0;
          st_nxt  = S_WR;
          if (st_r == S_WR_ACK)
          begin
            ptr_nxt = ptr_r + 8'h01;
          end
        end
        S_WR:
        begin
          if (cnt_r == 4'h8)
          begin
            wr_stb = 1'b1;
            oe_nxt = 1'b1;
            st_nxt = S_WR_ACK;
          end
        end
        S_RD:
        begin
          if (cnt_r == 4'h8)
          begin
            oe_nxt = 1'b0;
            st_nxt = S_RD_ACK;
          end
          else
          begin
            oe_nxt = !tx_r[6];
            tx_nxt = {tx_r[6:0], 1'b0};
          end
        end
        S_RD_ACK:
        begin
          if (!sh_r[0])
          begin
            ptr_nxt = ptr_r + 8'h01;
            tx_nxt  = rd_byte;
            oe_nxt  = !rd_byte[7];
            cnt_nxt = 4'h0;
            st_nxt  = S_RD;
          end
          else
          begin
            st_nxt = S_IDLE;
          end
        end
      endcase
    end
  end

  // Register next values; shutdown clears them synchronously since reset_n is the only async reset
  always_comb
  begin
    ref_lo_nxt = ref_lo_r;
    ref_hi_nxt = ref_hi_r;
    fb_nxt     = fb_r;
    ctrl_nxt   = ctrl_r;
    if (!awake_s)
    begin
      ref_lo_nxt = RST_REFERENCE_LOW;
      ref_hi_nxt = RST_REFERENCE_HIGH;
      fb_nxt     = RST_FEEDBACK_SELECT;
      ctrl_nxt   = RST_OUTPUT_CONTROL;
    end
    else if (wr_stb)
    begin
      unique case (ptr_r)
        REG_REFERENCE_LOW:   ref_lo_nxt = sh_r;
        REG_REFERENCE_HIGH:  ref_hi_nxt = sh_r[REF_HIGH_BITS-1:0];
        REG_FEEDBACK_SELECT: fb_nxt = sh_r;
        REG_OUTPUT_CONTROL:  ctrl_nxt = sh_r;
        default:             ref_lo_nxt = ref_lo_r;
      endcase
    end
  end

  // Converter controls, address latch and sync clock watch
  logic [7:0]  win_r, win_nxt;
  logic        sync_active_r, sync_active_nxt;
  logic [6:0]  addr_nxt;
  bbcs_drive_t drive_nxt;
  logic        ramp_en;
  logic [10:0] target_code;

  assign ramp_en     = run_s && ctrl_r[CTRL_OUTPUT_ENABLE];
  assign target_code = {ref_hi_r, ref_lo_r};

  always_comb
  begin
    addr_nxt = target_address_r;
    if (awake_s && !awake_q)
    begin
      addr_nxt = mode_s ? ADDR_MODE_HIGH : ADDR_MODE_LOW;
    end
    // Any edge within the window counts as an external clock; slower edges read as a static level
    win_nxt = (dpin_s != dpin_q) ? SYNC_WINDOW_CYCLES : ((win_r != 8'h00) ? win_r - 8'h01 : 8'h00);
    sync_active_nxt = (win_nxt != 8'h00);
    drive_nxt.switching = ramp_en;
    drive_nxt.discharge = run_s && (ctrl_r[CTRL_FORCED_DISCHARGE] ||
                          (!ctrl_r[CTRL_OUTPUT_ENABLE] && ctrl_r[CTRL_OFF_DISCHARGE] && vout_hi_s));
    // The fresh window is looked at too, so a clock edge that meets the band rising leaves no dither glitch
    drive_nxt.dither = ramp_en && band_s && !sync_active_nxt && !sync_active_r;
    drive_nxt.feedback_external = fb_r[FB_SOURCE_BIT];
    drive_nxt.internal_divider_ratio = fb_r[RATIO_LSB+1:RATIO_LSB];
  end

  // State registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      ref_lo_r <= RST_REFERENCE_LOW;
      ref_hi_r <= RST_REFERENCE_HIGH;
      fb_r <= RST_FEEDBACK_SELECT;
      ctrl_r <= RST_OUTPUT_CONTROL;
      target_address_r <= ADDR_MODE_LOW;
      win_r <= 8'h00;
      sync_active_r <= 1'b0;
      drive_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      sda_oe_r <= oe_nxt;
      sda_out_r <= 1'b0; // Open drain: only ever pulls low
      ref_lo_r <= ref_lo_nxt;
      ref_hi_r <= ref_hi_nxt;
      fb_r <= fb_nxt;
      ctrl_r <= ctrl_nxt;
      target_address_r <= addr_nxt;
      win_r <= win_nxt;
      sync_active_r <= sync_active_nxt;
      drive_r <= drive_nxt;
    end
  end

  bbcs_soft_start #(
    .STEP_CYCLES (STEP_CYC)
  ) u_soft_start (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .ramp_enable (ramp_en),
    .target_code (target_code),
    .ref_code_r  (reference_code),
    .done_r      (soft_start_done)
  );

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_addr_latch;
    (awake_s && !awake_q) |=> target_address_r == ($past(mode_s) ? ADDR_MODE_HIGH : ADDR_MODE_LOW);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched from select pin");

  property p_run_gate;
    !run_s |=> (!sda_oe_r && !drive_r.switching && st_r == S_IDLE);
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("bus or switching active below run level");

  property p_write_ctrl;
    (wr_stb && ptr_r == REG_OUTPUT_CONTROL && awake_s) |=> ctrl_r == $past(sh_r);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");

  property p_ramp_up;
    (ramp_en && $past(ramp_en) && $stable(target_code) && reference_code < target_code)
      |-> reference_code >= $past(reference_code);
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("reference ramp went backward");

  property p_shutdown;
    !awake_s |=> (ctrl_r == RST_OUTPUT_CONTROL && fb_r == RST_FEEDBACK_SELECT && ref_lo_r == RST_REFERENCE_LOW);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("registers kept through shutdown");

  property p_oe_off;
    (!ctrl_r[CTRL_OUTPUT_ENABLE]) |=> (!drive_r.switching && reference_code == 11'h000);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("switching without output enable");

  property p_off_discharge;
    (run_s && !ctrl_r[CTRL_OUTPUT_ENABLE] && ctrl_r[CTRL_OFF_DISCHARGE] && !ctrl_r[CTRL_FORCED_DISCHARGE])
      |=> drive_r.discharge == $past(vout_hi_s);
  endproperty
  a_off_discharge: assert property (p_off_discharge) else $error("off discharge wrong");

  property p_force_discharge;
    (run_s && ctrl_r[CTRL_FORCED_DISCHARGE]) |=> drive_r.discharge;
  endproperty
  a_force_discharge: assert property (p_force_discharge) else $error("forced discharge not on");

  property p_sync_no_dither;
    (dpin_s != dpin_q) |=> !drive_r.dither;
  endproperty
  a_sync_no_dither: assert property (p_sync_no_dither) else $error("dither with sync clock");

  property p_band_no_dither;
    !band_s |=> !drive_r.dither;
  endproperty
  a_band_no_dither: assert property (p_band_no_dither) else $error("dither with pin out of band");

  property p_feedback;
    ##1 (drive_r.feedback_external == $past(fb_r[FB_SOURCE_BIT])
         && drive_r.internal_divider_ratio == $past(fb_r[RATIO_LSB+1:RATIO_LSB]));
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback select not applied");

  c_read: cover property (st_r == S_RD_ACK && scl_fall && !sh_r[0]);
  c_ctrl_write: cover property (wr_stb && ptr_r == REG_OUTPUT_CONTROL);
  c_ramp_done: cover property (ramp_en && soft_start_done && target_code != 11'h000);
  c_discharge: cover property (drive_r.discharge && !ctrl_r[CTRL_FORCED_DISCHARGE]);

endmodule
`default_nettype wire

// ==== rtl/bbcs_soft_start.sv ====
// Reference ramp generator for soft start
`timescale 1ns/1ns
`default_nettype none
module bbcs_soft_start #(
  parameter int unsigned STEP_CYCLES = 43
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        ramp_enable,
  input  wire logic [10:0] target_code,
  output var  logic [10:0] ref_code_r,
  output var  logic        done_r
);
  import bbcs_pkg::*;

  localparam logic [16:0] STEP_M1 = 17'(STEP_CYCLES - 1);

  logic [16:0] step_cnt_r;
  logic [16:0] step_cnt_nxt;
  logic [10:0] ref_code_nxt;
  logic        done_nxt;

  // Climb one code per step; a lower target is followed at once, which avoids a slow fall
  always_comb
  begin
    step_cnt_nxt = step_cnt_r;
    ref_code_nxt = ref_code_r;
    if (!ramp_enable)
    begin
      step_cnt_nxt = 17'h00000;
      ref_code_nxt = 11'h000;
    end
    else if (ref_code_r > target_code)
    begin
      ref_code_nxt = target_code;
    end
    else if (ref_code_r < target_code)
    begin
      if (step_cnt_r >= STEP_M1)
      begin
        step_cnt_nxt = 17'h00000;
        ref_code_nxt = ref_code_r + 11'h001;
      end
      else
      begin
        step_cnt_nxt = step_cnt_r + 17'h00001;
      end
    end
    done_nxt = ramp_enable && (ref_code_nxt == target_code);
  end

  // Ramp state
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      step_cnt_r <= 17'h00000;
      ref_code_r <= 11'h000;
      done_r     <= 1'b0;
    end
    else
    begin
      step_cnt_r <= step_cnt_nxt;
      ref_code_r <= ref_code_nxt;
      done_r     <= done_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/bbcs_i2c_host.sv ====
// I2C controller model that reaches the sequencer's register target
`timescale 1ns/1ns
`default_nettype none
module bbcs_i2c_host (
  input  wire logic core_clk,
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_low
);
  // Bus idles released; the pull-up on the wire gives the high level
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Levels last several core cycles because the target synchronises both lines
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // START, or repeated START when entered with the clock low
  task automatic start();
    sda_low = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b1;
    hold(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hold(6);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b0;
    hold(8);
  endtask

  // Data changes only while the clock is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic seen);
    sda_low = ~b;
    hold(6);
    scl = 1'b1;
    hold(4);
    seen = sda_in;
    hold(4);
    scl = 1'b0;
  endtask

  // Byte out; ack is high when the target pulled the ninth bit low
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Byte in, then acknowledge when more bytes follow
  task automatic get(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the buck-boost control sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import bbcs_pkg::*;
  localparam int unsigned SS_CYC = 4096;
  localparam logic [10:0] TGT    = 11'h0C8;
  logic                   core_clk;
  logic                   reset_n;
  logic                   awake;
  logic                   run;
  logic                   mode_pin;
  logic                   sync_pin;
  logic                   in_band;
  logic                   vout_hi;
  logic                   a;
  logic [7:0]             d;
  int                     fail_count;
  int                     n_tests;
  wire logic              scl;
  wire logic              host_low;
  wire logic              sda_out_r;
  wire logic              sda_oe_r;
  wire logic              done;
  wire logic              sda;
  wire logic [6:0]        target_address_r;
  wire logic [10:0]       reference_code;
  wire bbcs_drive_t       drive_r;

  // Open-drain wire: low while either party pulls, else the pull-up
  assign sda = ~(host_low | (sda_oe_r & ~sda_out_r));

  bbcs_i2c_host i_host (.core_clk(core_clk), .sda_in(sda), .scl(scl), .sda_low(host_low));

  bbcs_sequencer #(.SOFT_START_CYC(SS_CYC)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .enable_lockout_pin_awake(awake),
    .enable_lockout_pin_run(run), .mode_pin(mode_pin), .scl_in(scl), .sda_in(sda),
    .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r), .spread_or_sync_pin(sync_pin),
    .spread_pin_in_band(in_band), .vout_above_discharge_level(vout_hi),
    .target_address_r(target_address_r), .reference_code(reference_code),
    .soft_start_done(done), .drive_r(drive_r));

  // 25 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pointer write then data byte; ack is the and of all three acknowledges
  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] dat, output logic ack);
    logic k1, k2, k3;
    i_host.start();
    i_host.put({dev, 1'b0}, k1);
    i_host.put(adr, k2);
    i_host.put(dat, k3);
    i_host.stop();
    ack = k1 & k2 & k3;
  endtask

  // Random read: pointer write, repeated START, one byte with NACK
  task automatic reg_rd(input logic [6:0] dev, input logic [7:0] adr, output logic [7:0] dat);
    logic k;
    i_host.start();
    i_host.put({dev, 1'b0}, k);
    i_host.put(adr, k);
    i_host.start();
    i_host.put({dev, 1'b1}, k);
    i_host.get(1'b0, dat);
    i_host.stop();
  endtask

  // Watchdog well beyond the expected run of about half a millisecond, still far below the cycle budget
  initial
  begin
    #2000000;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    logic [7:0] regs [5];
    regs = '{REG_REFERENCE_LOW, REG_REFERENCE_HIGH, REG_FEEDBACK_SELECT, REG_OUTPUT_CONTROL, 8'h02};
    {reset_n, awake, run, mode_pin, sync_pin, in_band, vout_hi} = 7'h00;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    awake = 1'b1;
    i_host.hold(4);
    run = 1'b1;
    i_host.hold(4);
    // Reset values, unmapped place included
    check("address", ADDR_MODE_LOW, target_address_r);
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(ADDR_MODE_LOW, regs[i], d);
      check("reset value", 8'h00, d);
    end
    $display("Test reset done");
    // No traffic below the run threshold
    run = 1'b0;
    i_host.hold(4);
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h80, a);
    check("ack with run low", 1'b0, a);
    check("switching", 1'b0, drive_r.switching);
    run = 1'b1;
    i_host.hold(4);
    $display("Test lockout done");
    // Configuration before output enable; upper reference bits only three wide
    reg_wr(ADDR_MODE_LOW, REG_REFERENCE_HIGH, 8'hFF, a);
    check("ack", 1'b1, a);
    reg_rd(ADDR_MODE_LOW, REG_REFERENCE_HIGH, d);
    check("reference_high", 8'h07, d);
    reg_wr(ADDR_MODE_LOW, REG_REFERENCE_HIGH, 8'h00, a);
    reg_wr(ADDR_MODE_LOW, REG_REFERENCE_LOW, TGT[7:0], a);
    reg_rd(ADDR_MODE_LOW, REG_REFERENCE_LOW, d);
    check("reference_low", TGT[7:0], d);
    for (int r = 0; r < 4; r++)
    begin
      reg_wr(ADDR_MODE_LOW, REG_FEEDBACK_SELECT, 8'(r), a);
      check("ratio", 11'(r), drive_r.internal_divider_ratio);
      check("feedback external", 1'b0, drive_r.feedback_external);
    end
    reg_wr(ADDR_MODE_LOW, REG_FEEDBACK_SELECT, 8'h80, a);
    check("feedback external", 1'b1, drive_r.feedback_external);
    $display("Test configuration done");
    // Soft start ramps from zero to the programmed code
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h80, a);
    check("switching", 1'b1, drive_r.switching);
    check("ramp below target", 1'b1, reference_code < TGT);
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(negedge core_clk);
    check("reference code", TGT, reference_code);
    check("soft start done", 1'b1, done);
    $display("Test soft start done");
    // Dither needs the mid band and no external clock
    in_band = 1'b1;
    i_host.hold(5);
    check("dither", 1'b1, drive_r.dither);
    in_band = 1'b0;
    i_host.hold(5);
    check("dither", 1'b0, drive_r.dither);
    in_band = 1'b1;
    // External clock of 1 MHz, taken as inside the allowed band of the set rate
    for (int i = 0; i < 40; i++)
    begin
      sync_pin = ~sync_pin;
      i_host.hold(12);
      check("dither with sync", 1'b0, drive_r.dither);
    end
    i_host.hold(260);
    check("dither after sync", 1'b1, drive_r.dither);
    $display("Test dither done");
    // Output enable cleared: switching stops, bus stays usable
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h00, a);
    check("switching", 1'b0, drive_r.switching);
    check("reference code", 11'h000, reference_code);
    reg_rd(ADDR_MODE_LOW, REG_FEEDBACK_SELECT, d);
    check("feedback_select", 8'h80, d);
    // Discharge paths, each left on far less than ten milliseconds
    vout_hi = 1'b1;
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h10, a);
    check("off discharge", 1'b1, drive_r.discharge);
    vout_hi = 1'b0;
    i_host.hold(5);
    check("discharge at low output", 1'b0, drive_r.discharge);
    vout_hi = 1'b1;
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h90, a);
    check("discharge while enabled", 1'b0, drive_r.discharge);
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'hA0, a);
    check("forced discharge", 1'b1, drive_r.discharge);
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h90, a);
    $display("Test discharge done");
    // Shutdown clears everything; the address is fixed again on wake
    awake = 1'b0;
    run = 1'b0;
    mode_pin = 1'b1;
    i_host.hold(5);
    check("drive in shutdown", 6'h00, drive_r);
    awake = 1'b1;
    i_host.hold(5);
    check("address", ADDR_MODE_HIGH, target_address_r);
    run = 1'b1;
    i_host.hold(5);
    reg_rd(ADDR_MODE_HIGH, REG_OUTPUT_CONTROL, d);
    check("output_control", RST_OUTPUT_CONTROL, d);
    reg_rd(ADDR_MODE_HIGH, REG_FEEDBACK_SELECT, d);
    check("feedback_select", RST_FEEDBACK_SELECT, d);
    reg_wr(ADDR_MODE_LOW, REG_OUTPUT_CONTROL, 8'h80, a);
    check("ack old address", 1'b0, a);
    check("switching", 1'b0, drive_r.switching);
    $display("Test shutdown done");
    end_of_test();
  end
endmodule
`default_nettype wire
